// *** verilog/tiam_params.svh ***
// offsets, field positions and reset values of the timer irq mask and alarm block
`ifndef TIAM_PARAMS_SVH
`define TIAM_PARAMS_SVH
`define TIAM_ADDR_W 12
`define TIAM_DATA_W 32
`define TIAM_OFS_FLAGS 12'h010
`define TIAM_OFS_IRQ_EN 12'h014
`define TIAM_OFS_IRQ_DIS 12'h018
`define TIAM_OFS_MASK 12'h01c
`define TIAM_OFS_ALARM 12'h020
`define TIAM_OFS_COUNT 12'h024
`define TIAM_OFS_CLEAR 12'h028
`define TIAM_NUM_EVT 4
`define TIAM_BIT_PERIOD 0
`define TIAM_BIT_WDOG 1
`define TIAM_BIT_TICK 2
`define TIAM_BIT_ALARM 3
`define TIAM_CNT_W 20
`define TIAM_MASK_RST 4'h0
`define TIAM_FLAGS_RST 4'h0
`define TIAM_ALL_EVT 4'hf
`define TIAM_NO_EVT 4'h0
`define TIAM_ALARM_RST 20'h00000
`define TIAM_COUNT_RST 20'h00000
`define TIAM_WORD_RST 32'h00000000
`define TIAM_RST_SYNC_RST 2'h0
`endif

// *** verilog/tiam_pkg.sv ***
// shared types of the timer irq mask and alarm block
`include "tiam_params.svh"
package tiam_pkg;
  typedef logic [`TIAM_NUM_EVT-1:0] tiam_evt_t;
  typedef logic [`TIAM_CNT_W-1:0] tiam_cnt_t;
  typedef logic [`TIAM_ADDR_W-1:0] tiam_addr_t;
  typedef logic [`TIAM_DATA_W-1:0] tiam_word_t;
endpackage

// *** verilog/tiam_evt_sync.sv ***
// two-flop synchroniser turning a slow-domain event level into one master-clock pulse
`timescale 1ns/1ps
`default_nettype none
module tiam_evt_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstSyncN,
  // slow-domain event level
  input wire logic evtIn,
  // master-clock event pulse
  output logic evtPulse
);
  logic meta;
  logic stable;
  logic prev;

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
      evtPulse <= 1'b0;
    end else begin
      meta <= evtIn;
      stable <= meta;
      prev <= stable;
      evtPulse <= stable & ~prev;
    end
  end

  a_evt_sync_delay: assert property (@(posedge clk) disable iff (!rstSyncN)
    ($rose(evtIn) ##1 evtIn) |-> ##2 evtPulse)
    else $error("event pulse not three cycles after input edge");
endmodule
`default_nettype wire

// *** verilog/tiam_cnt_sync.sv ***
// brings the slow-domain real-time count across, accepting a value only once it holds still
`timescale 1ns/1ps
`default_nettype none
module tiam_cnt_sync
  import tiam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstSyncN,
  // slow-domain counter
  input wire tiam_cnt_t cntIn,
  // master-clock copy
  output tiam_cnt_t cntValue,
  output logic cntUpdate
);
  tiam_cnt_t meta;
  tiam_cnt_t stage2;
  tiam_cnt_t stage3;

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      meta <= `TIAM_COUNT_RST;
      stage2 <= `TIAM_COUNT_RST;
      stage3 <= `TIAM_COUNT_RST;
      cntValue <= `TIAM_COUNT_RST;
      cntUpdate <= 1'b0;
    end else begin
      meta <= cntIn;
      stage2 <= meta;
      stage3 <= stage2;
      // two equal samples rule out a word caught mid-change
      if (stage2 == stage3 && stage3 != cntValue) begin
        cntValue <= stage3;
        cntUpdate <= 1'b1;
      end else begin
        cntUpdate <= 1'b0;
      end
    end
  end

  a_cnt_update_pulse: assert property (@(posedge clk) disable iff (!rstSyncN)
    cntUpdate |-> (cntValue != $past(cntValue)) ##1 !cntUpdate)
    else $error("count update pulse without a new value");
endmodule
`default_nettype wire

// *** verilog/tiam_top.sv ***
// timer interrupt mask, real-time alarm and event flags behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "tiam_params.svh"
module tiam_top
  import tiam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire tiam_addr_t paddr,
  input wire tiam_word_t pwdata,
  output tiam_word_t prdata,
  output logic pready,
  output logic pslverr,
  // slow-domain timer events and real-time count
  input wire logic periodEvent,
  input wire logic watchdogEvent,
  input wire tiam_cnt_t rtCounter,
  // interrupt toward the interrupt controller
  output logic timerIrq
);
  logic [1:0] rstPipe;
  logic rstSyncN;
  tiam_evt_t maskState;
  tiam_evt_t eventFlags;
  tiam_cnt_t alarmValue;
  tiam_cnt_t cntValue;
  logic cntUpdate;
  logic periodPulse;
  logic watchdogPulse;
  logic alarmHit;
  logic setupRead;
  logic accessWrite;
  logic accessRead;
  tiam_evt_t wrBits;
  tiam_evt_t setVec;
  tiam_evt_t clrVec;
  tiam_evt_t next_maskState;
  tiam_evt_t next_eventFlags;

  function automatic logic regHit(input tiam_addr_t addr, input tiam_addr_t ofs);
    regHit = (addr == ofs);
  endfunction

  function automatic logic isMapped(input tiam_addr_t addr);
    isMapped = regHit(addr, `TIAM_OFS_FLAGS) || regHit(addr, `TIAM_OFS_IRQ_EN) ||
      regHit(addr, `TIAM_OFS_IRQ_DIS) || regHit(addr, `TIAM_OFS_MASK) ||
      regHit(addr, `TIAM_OFS_ALARM) || regHit(addr, `TIAM_OFS_COUNT) ||
      regHit(addr, `TIAM_OFS_CLEAR);
  endfunction

  function automatic tiam_word_t evtWord(input tiam_evt_t bits);
    evtWord = {{(`TIAM_DATA_W-`TIAM_NUM_EVT){1'b0}}, bits};
  endfunction

  function automatic tiam_word_t cntWord(input tiam_cnt_t val);
    cntWord = {{(`TIAM_DATA_W-`TIAM_CNT_W){1'b0}}, val};
  endfunction

  function automatic tiam_evt_t onlyBit(input int idx);
    onlyBit = `TIAM_NO_EVT;
    onlyBit[idx] = 1'b1;
  endfunction

  // reset released through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= `TIAM_RST_SYNC_RST;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe[1];

  // slow-domain crossings
  tiam_evt_sync periodSync (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .evtIn(periodEvent),
    .evtPulse(periodPulse)
  );

  tiam_evt_sync watchdogSync (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .evtIn(watchdogEvent),
    .evtPulse(watchdogPulse)
  );

  tiam_cnt_sync counterSync (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .cntIn(rtCounter),
    .cntValue(cntValue),
    .cntUpdate(cntUpdate)
  );

  // apb decode; zero wait states
  assign pready = 1'b1;
  assign setupRead = psel & ~penable & ~pwrite;
  assign accessWrite = psel & penable & pwrite;
  assign accessRead = psel & penable & ~pwrite;
  assign pslverr = psel & penable & ~isMapped(paddr);
  assign wrBits = pwdata[`TIAM_NUM_EVT-1:0];

  // mask built from set and clear commands
  always_comb begin
    next_maskState = maskState;
    if (accessWrite && regHit(paddr, `TIAM_OFS_IRQ_EN)) begin
      next_maskState = maskState | wrBits;
    end
    if (accessWrite && regHit(paddr, `TIAM_OFS_IRQ_DIS)) begin
      next_maskState = maskState & ~wrBits;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      maskState <= `TIAM_MASK_RST;
    end else begin
      maskState <= next_maskState;
    end
  end

  // alarm value
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      alarmValue <= `TIAM_ALARM_RST;
    end else if (accessWrite && regHit(paddr, `TIAM_OFS_ALARM)) begin
      alarmValue <= pwdata[`TIAM_CNT_W-1:0];
    end
  end

  // match only on a fresh count, so alarm zero waits a full wrap
  assign alarmHit = cntUpdate && (cntValue == alarmValue);

  always_comb begin
    setVec = `TIAM_NO_EVT;
    setVec[`TIAM_BIT_PERIOD] = periodPulse;
    setVec[`TIAM_BIT_WDOG] = watchdogPulse;
    setVec[`TIAM_BIT_TICK] = cntUpdate;
    setVec[`TIAM_BIT_ALARM] = alarmHit;
  end

  // a read clears only the bits it returned; later events survive
  always_comb begin
    clrVec = `TIAM_NO_EVT;
    if (accessRead && regHit(paddr, `TIAM_OFS_FLAGS)) begin
      clrVec = prdata[`TIAM_NUM_EVT-1:0];
    end
    if (accessWrite && regHit(paddr, `TIAM_OFS_CLEAR)) begin
      clrVec = clrVec | wrBits;
    end
    next_eventFlags = (eventFlags & ~clrVec) | setVec;
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      eventFlags <= `TIAM_FLAGS_RST;
    end else begin
      eventFlags <= next_eventFlags;
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      prdata <= `TIAM_WORD_RST;
    end else if (setupRead) begin
      if (regHit(paddr, `TIAM_OFS_FLAGS)) begin
        prdata <= evtWord(eventFlags);
      end else if (regHit(paddr, `TIAM_OFS_MASK)) begin
        prdata <= evtWord(maskState);
      end else if (regHit(paddr, `TIAM_OFS_ALARM)) begin
        prdata <= cntWord(alarmValue);
      end else if (regHit(paddr, `TIAM_OFS_COUNT)) begin
        prdata <= cntWord(cntValue);
      end else begin
        prdata <= `TIAM_WORD_RST;
      end
    end
  end

  // level interrupt
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= |(next_eventFlags & next_maskState);
    end
  end

  a_enable_sets_bits: assert property (@(posedge clk) disable iff (!rstSyncN)
    (accessWrite && paddr == `TIAM_OFS_IRQ_EN) |=>
      (maskState == ($past(maskState) | $past(wrBits))))
    else $error("enable command did not set the written bits");

  a_disable_clears_bits: assert property (@(posedge clk) disable iff (!rstSyncN)
    (accessWrite && paddr == `TIAM_OFS_IRQ_DIS) |=>
      (maskState == ($past(maskState) & ~$past(wrBits))))
    else $error("disable command did not clear the written bits");

  a_mask_read_back: assert property (@(posedge clk) disable iff (!rstSyncN)
    (setupRead && paddr == `TIAM_OFS_MASK) |=> (prdata == evtWord($past(maskState))))
    else $error("mask read does not show the mask");

  a_mask_alarm_bit: assert property (@(posedge clk) disable iff (!rstSyncN)
    (accessWrite && paddr == `TIAM_OFS_IRQ_EN && wrBits == onlyBit(`TIAM_BIT_ALARM)) |=>
      (maskState[`TIAM_BIT_ALARM] && maskState[`TIAM_BIT_TICK:0] == $past(maskState[`TIAM_BIT_TICK:0])))
    else $error("alarm enable is not bit 3");

  a_tick_enable_alone: assert property (@(posedge clk) disable iff (!rstSyncN)
    (accessWrite && paddr == `TIAM_OFS_IRQ_EN && wrBits == onlyBit(`TIAM_BIT_TICK)) |=>
      (maskState[`TIAM_BIT_TICK] && $stable(maskState[`TIAM_BIT_ALARM])))
    else $error("tick enable disturbed the alarm enable");

  a_alarm_write_back: assert property (@(posedge clk) disable iff (!rstSyncN)
    (accessWrite && paddr == `TIAM_OFS_ALARM) ##1
      (setupRead && paddr == `TIAM_OFS_ALARM && !accessWrite) |=>
      (prdata == cntWord($past(alarmValue)) && alarmValue == $past(pwdata[`TIAM_CNT_W-1:0], 2)))
    else $error("alarm value not stored or read back");

  a_alarm_zero_waits: assert property (@(posedge clk) disable iff (!rstSyncN)
    (alarmValue == `TIAM_ALARM_RST && !cntUpdate) |=> !$rose(eventFlags[`TIAM_BIT_ALARM]) ||
      $past(accessWrite))
    else $error("alarm zero fired without a counter wrap");

  a_count_read: assert property (@(posedge clk) disable iff (!rstSyncN)
    (setupRead && paddr == `TIAM_OFS_COUNT) |=> (prdata == cntWord($past(cntValue))))
    else $error("count read does not show the synchronised counter");

  a_flags_stick: assert property (@(posedge clk) disable iff (!rstSyncN)
    (clrVec == `TIAM_NO_EVT) |=> ((eventFlags & $past(eventFlags)) == $past(eventFlags)))
    else $error("flag dropped without a status read");

  a_flags_read_clear: assert property (@(posedge clk) disable iff (!rstSyncN)
    (accessRead && paddr == `TIAM_OFS_FLAGS && setVec == `TIAM_NO_EVT) |=>
      ((eventFlags & $past(prdata[`TIAM_NUM_EVT-1:0])) == `TIAM_NO_EVT))
    else $error("status read did not clear the returned flags");

  a_alarm_match_flag: assert property (@(posedge clk) disable iff (!rstSyncN)
    (cntUpdate && cntValue == alarmValue) |=> eventFlags[`TIAM_BIT_ALARM])
    else $error("alarm match did not raise the alarm flag");

  a_tick_flag_set: assert property (@(posedge clk) disable iff (!rstSyncN)
    cntUpdate |=> eventFlags[`TIAM_BIT_TICK])
    else $error("counter advance did not raise the tick flag");

  a_irq_follows_flags: assert property (@(posedge clk) disable iff (!rstSyncN)
    ##1 (timerIrq == |(eventFlags & maskState)))
    else $error("interrupt does not match enabled flags");

  a_period_to_irq: assert property (@(posedge clk) disable iff (!rstSyncN)
    (periodPulse && maskState[`TIAM_BIT_PERIOD] && next_maskState[`TIAM_BIT_PERIOD]) |=> timerIrq)
    else $error("enabled period event did not raise the interrupt");

  a_unmapped_error: assert property (@(posedge clk) disable iff (!rstSyncN)
    (psel && penable && !isMapped(paddr)) |-> pslverr ##1 $stable(maskState) || $past(setVec) != 0)
    else $error("unmapped access not answered with an error");

  a_event_crossing: assert property (@(posedge clk) disable iff (!rstSyncN)
    ($rose(periodEvent) ##1 periodEvent [*3]) |=> eventFlags[`TIAM_BIT_PERIOD])
    else $error("period event not flagged after synchronisation");

  // reset values seen at the first edge out of reset
  a_mask_reset_zero: assert property (@(posedge clk) disable iff (!rstSyncN)
    $rose(rstSyncN) |-> (maskState == `TIAM_MASK_RST))
    else $error("mask not zero after reset");

  a_alarm_reset_zero: assert property (@(posedge clk) disable iff (!rstSyncN)
    $rose(rstSyncN) |-> (alarmValue == `TIAM_ALARM_RST))
    else $error("alarm value not zero after reset");

  a_count_reset_zero: assert property (@(posedge clk) disable iff (!rstSyncN)
    $rose(rstSyncN) |-> (cntValue == `TIAM_COUNT_RST))
    else $error("counter copy not zero after reset");

  a_flags_reset_zero: assert property (@(posedge clk) disable iff (!rstSyncN)
    $rose(rstSyncN) |-> (eventFlags == `TIAM_FLAGS_RST && !timerIrq))
    else $error("flags or interrupt set after reset");

  // mask and alarm change only through their own writes
  a_mask_only_cmds: assert property (@(posedge clk) disable iff (!rstSyncN)
    !(accessWrite && (paddr == `TIAM_OFS_IRQ_EN || paddr == `TIAM_OFS_IRQ_DIS)) |=> $stable(maskState))
    else $error("mask changed without a command");

  a_enable_keeps_rest: assert property (@(posedge clk) disable iff (!rstSyncN)
    (accessWrite && paddr == `TIAM_OFS_IRQ_EN) |=>
      ((maskState & ~$past(wrBits)) == ($past(maskState) & ~$past(wrBits))))
    else $error("enable command touched unwritten bits");

  a_disable_keeps_rest: assert property (@(posedge clk) disable iff (!rstSyncN)
    (accessWrite && paddr == `TIAM_OFS_IRQ_DIS) |=>
      ((maskState | $past(wrBits)) == ($past(maskState) | $past(wrBits))))
    else $error("disable command touched unwritten bits");

  a_alarm_only_write: assert property (@(posedge clk) disable iff (!rstSyncN)
    !(accessWrite && paddr == `TIAM_OFS_ALARM) |=> $stable(alarmValue))
    else $error("alarm value changed without a write");

  a_count_moves_update: assert property (@(posedge clk) disable iff (!rstSyncN)
    $changed(cntValue) |-> cntUpdate)
    else $error("counter copy changed without an update pulse");

  // tick and alarm flags raised only by their own source
  a_tick_from_update: assert property (@(posedge clk) disable iff (!rstSyncN)
    $rose(eventFlags[`TIAM_BIT_TICK]) |-> $past(cntUpdate))
    else $error("tick flag rose without a counter advance");

  a_alarm_from_match: assert property (@(posedge clk) disable iff (!rstSyncN)
    $rose(eventFlags[`TIAM_BIT_ALARM]) |-> $past(alarmHit))
    else $error("alarm flag rose without a match");

  a_set_beats_clear: assert property (@(posedge clk) disable iff (!rstSyncN)
    (setVec != `TIAM_NO_EVT) |=> ((eventFlags & $past(setVec)) == $past(setVec)))
    else $error("clear in the same cycle beat an event");

  a_irq_low_masked: assert property (@(posedge clk) disable iff (!rstSyncN)
    (next_maskState == `TIAM_NO_EVT) |=> !timerIrq)
    else $error("interrupt raised with every source masked");

  a_cmd_read_zero: assert property (@(posedge clk) disable iff (!rstSyncN)
    (setupRead && (paddr == `TIAM_OFS_IRQ_EN || paddr == `TIAM_OFS_IRQ_DIS || paddr == `TIAM_OFS_CLEAR)) |=>
      (prdata == `TIAM_WORD_RST))
    else $error("write-only register did not read zero");
endmodule
`default_nettype wire

// *** sim/tiam_slow_model.sv ***
// model of the slow-clock timer logic feeding events and the real-time count
`timescale 1ns/1ps
`default_nettype none
module tiam_slow_model
  import tiam_pkg::*;
(
  // clock
  input wire logic clk,
  // events and count toward the block
  output logic periodEvent,
  output logic watchdogEvent,
  output tiam_cnt_t rtCounter
);
  initial begin
    periodEvent = 1'b0;
    watchdogEvent = 1'b0;
    rtCounter = 20'h00000;
  end
  // level held four clocks, beyond the three-clock minimum
  task automatic fire(input int which);
    @(posedge clk);
    if (which == 0) begin
      periodEvent <= 1'b1;
    end else begin
      watchdogEvent <= 1'b1;
    end
    repeat (4) @(posedge clk);
    periodEvent <= 1'b0;
    watchdogEvent <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // each value held long enough to be accepted and flagged
  task automatic setCount(input tiam_cnt_t v);
    @(posedge clk);
    rtCounter <= v;
    repeat (10) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** sim/tb_tiam_top.sv ***
// self-checking testbench of the timer irq mask and alarm block
`timescale 1ns/1ps
`default_nettype none
`include "tiam_params.svh"
module tb_tiam_top
  import tiam_pkg::*;
;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  tiam_addr_t paddr;
  tiam_word_t pwdata;
  tiam_word_t prdata;
  logic pready;
  logic pslverr;
  logic periodEvent;
  logic watchdogEvent;
  tiam_cnt_t rtCounter;
  logic timerIrq;
  int err_total;
  int checks_done;
  tiam_word_t rdata;
  logic rerr;
  logic chained;

  tiam_top uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periodEvent(periodEvent), .watchdogEvent(watchdogEvent), .rtCounter(rtCounter),
    .timerIrq(timerIrq)
  );
  tiam_slow_model slow (
    .clk(clk), .periodEvent(periodEvent), .watchdogEvent(watchdogEvent), .rtCounter(rtCounter)
  );

  initial begin
    clk = 1'b0;
  end
  always #10 clk = ~clk;

  task automatic results();
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input tiam_word_t exp, input tiam_word_t got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  // one apb transfer: setup, access held until pready sampled high
  // more keeps psel up so the next setup follows the access at once
  task automatic xfer(input tiam_addr_t a, input logic w, input tiam_word_t d, input logic more);
    int n;
    n = 0;
    if (!chained) begin
      @(posedge clk);
    end
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) begin
      err_total++;
      results();
    end
    rdata = prdata;
    rerr = pslverr;
    chained = more;
    if (!more) begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input tiam_addr_t a, input tiam_word_t d);
    xfer(a, 1'b1, d, 1'b0);
    chk("write error", 32'h00000000, {31'h0, rerr});
  endtask

  task automatic rd(input string name, input tiam_addr_t a, input tiam_word_t exp);
    xfer(a, 1'b0, 32'h00000000, 1'b0);
    chk(name, exp, rdata);
  endtask

  // looked at mid-cycle, after the edge that updates it
  task automatic irqIs(input logic exp);
    @(negedge clk);
    chk("timerIrq", {31'h0, exp}, {31'h0, timerIrq});
  endtask

  initial begin
    #400000;
    err_total++;
    results();
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    chained = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd("mask", `TIAM_OFS_IRQ_DIS + 12'h004, 32'h00000000);
    rd("alarm", `TIAM_OFS_ALARM, 32'h00000000);
    rd("count", `TIAM_OFS_COUNT, 32'h00000000);
    rd("flags", `TIAM_OFS_FLAGS, 32'h00000000);
    irqIs(1'b0);
    // each source alone in its own bit position
    for (int i = 0; i < 4; i++) begin
      wr(`TIAM_OFS_IRQ_DIS, 32'h0000000f);
      wr(`TIAM_OFS_IRQ_EN, 32'h00000001 << i);
      rd("mask bit", `TIAM_OFS_MASK, 32'h00000001 << i);
    end
    wr(`TIAM_OFS_IRQ_EN, 32'h00000004);
    rd("mask or", `TIAM_OFS_MASK, 32'h0000000c);
    wr(`TIAM_OFS_IRQ_DIS, 32'h00000008);
    rd("mask tick", `TIAM_OFS_MASK, 32'h00000004);
    wr(`TIAM_OFS_IRQ_DIS, 32'h00000000);
    wr(`TIAM_OFS_IRQ_EN, 32'hfffffff0);
    wr(`TIAM_OFS_MASK, 32'h0000000f);
    rd("mask kept", `TIAM_OFS_MASK, 32'h00000004);
    rd("enable cmd read", `TIAM_OFS_IRQ_EN, 32'h00000000);
    wr(`TIAM_OFS_IRQ_DIS, 32'h0000000f);
    xfer(`TIAM_OFS_ALARM, 1'b1, 32'hfff12345, 1'b1);
    chk("alarm write error", 32'h00000000, {31'h0, rerr});
    rd("alarm rw", `TIAM_OFS_ALARM, 32'h00012345);
    xfer(12'h030, 1'b0, 32'h00000000, 1'b0);
    chk("unmapped err", 32'h00000001, {31'h0, rerr});
    chk("unmapped data", 32'h00000000, rdata);
    // period and watchdog events: masked, then enabled
    for (int e = 0; e < 2; e++) begin
      slow.fire(e);
      irqIs(1'b0);
      rd("flag set", `TIAM_OFS_FLAGS, 32'h00000001 << e);
      rd("flag cleared", `TIAM_OFS_FLAGS, 32'h00000000);
      wr(`TIAM_OFS_IRQ_EN, 32'h00000001 << e);
      slow.fire(e);
      irqIs(1'b1);
      rd("flag irq", `TIAM_OFS_FLAGS, 32'h00000001 << e);
      irqIs(1'b0);
      wr(`TIAM_OFS_IRQ_DIS, 32'h0000000f);
    end
    wr(`TIAM_OFS_ALARM, 32'h00000005);
    slow.setCount(20'h00004);
    rd("tick", `TIAM_OFS_FLAGS, 32'h00000004);
    wr(`TIAM_OFS_IRQ_EN, 32'h00000008);
    slow.setCount(20'h00005);
    irqIs(1'b1);
    rd("count now", `TIAM_OFS_COUNT, 32'h00000005);
    rd("alarm hit", `TIAM_OFS_FLAGS, 32'h0000000c);
    slow.setCount(20'h00006);
    irqIs(1'b0);
    rd("no alarm", `TIAM_OFS_FLAGS, 32'h00000004);
    // alarm zero fires only on the wrap
    wr(`TIAM_OFS_ALARM, 32'h00000000);
    slow.setCount(20'hfffff);
    rd("before wrap", `TIAM_OFS_FLAGS, 32'h00000004);
    rd("count top", `TIAM_OFS_COUNT, 32'h000fffff);
    slow.setCount(20'h00000);
    irqIs(1'b1);
    rd("wrap alarm", `TIAM_OFS_FLAGS, 32'h0000000c);
    slow.fire(0);
    wr(`TIAM_OFS_CLEAR, 32'h00000001);
    rd("clear reg", `TIAM_OFS_FLAGS, 32'h00000000);
    // second reset in mid-run drops mask and alarm
    wr(`TIAM_OFS_IRQ_EN, 32'h00000003);
    wr(`TIAM_OFS_ALARM, 32'h00000077);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd("mask reset", `TIAM_OFS_MASK, 32'h00000000);
    rd("alarm reset", `TIAM_OFS_ALARM, 32'h00000000);
    irqIs(1'b0);
    results();
  end
endmodule
`default_nettype wire
